// ### design/ascp_device.sv
// Amplifier serial control port: bus slave and register bank
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ascp_consts.svh"

// Functional notes
// - Link works up to 400 kHz clock
// - Master keeps data stable while clock high
// - Slave only, never drives clock line
// - Transfers framed by START and STOP
// - Eight-bit bytes, each followed by acknowledge
// - Answer address 1101111, direction 0 writes
// - Sample data on clock rising edge
// - Acknowledge address match, else stay released
// - Register address byte received and acknowledged
// - Write data acknowledged and stored
// - Read returns selected register, MSB first
// - Four registers at 0x00 to 0x03
// - Run, boost, input select; upper bits zero
// - Bit 3 picks fast or normal wake
// - Bits 6:5 release time code
// - Bits 4:3 attack time code
// - Bits 2:0 limit code, 000/111 off
// - Gain code bits 1:0, upper zero
// - Hardware mode: pins pick input, gain
// - Mode pin selects hardware or register control
// - Limiter only in register mode with boost
// - Shutdown pin low disables amp and boost
module ascp_device (
    input  wire logic   clk,
    input  wire logic   rstn,
    ascp_if.device      bus,
    input  wire logic   controlSourcePin,
    input  wire logic   runEnable,
    output logic        ampOn,
    output logic        boostOn,
    output logic        secondInput,
    output logic        fastWake,
    output logic [1:0]  levelCode,
    output logic        limiterOn,
    output logic [1:0]  onsetCode,
    output logic [1:0]  recoveryCode,
    output logic [2:0]  capCode
);
    import ascp_pkg::*;

    ascp_dev_t r;
    ascp_dev_t n;
    logic      sclH;
    logic      sdaH;
    logic      sclRise;
    logic      sclFall;
    logic      startC;
    logic      stopC;
    logic      swMode;
    logic      runPin;
    logic [7:0] rdData;
    logic [2:0] cap;

    // Edges and bus conditions from synchronised lines
    assign sclH    = r.sclSync[1];
    assign sdaH    = r.sdaSync[1];
    assign sclRise = sclH && !r.sclPrev;
    assign sclFall = !sclH && r.sclPrev;
    assign startC  = sclH && r.sclPrev && r.sdaPrev && !sdaH;
    assign stopC   = sclH && r.sclPrev && !r.sdaPrev && sdaH;
    assign swMode  = r.modeSync[1];
    assign runPin  = r.runSync[1];
    assign cap     = r.lim[`ASCP_LIM_CAP_LSB +: 3];

    // Read mux; test and unmapped read as zero
    always_comb begin
        case (r.regAddr)
            `ASCP_REG_PWR:  rdData = r.pwr;
            `ASCP_REG_LIM:  rdData = r.lim;
            `ASCP_REG_GAIN: rdData = r.gain;
            default:        rdData = 8'h00;
        endcase
    end

    // Next state
    always_comb begin
        n = r;
        n.sclSync  = {r.sclSync[0], bus.scl};
        n.sclPrev  = r.sclSync[1];
        n.sdaSync  = {r.sdaSync[0], bus.sda};
        n.sdaPrev  = r.sdaSync[1];
        n.modeSync = {r.modeSync[0], controlSourcePin};
        n.runSync  = {r.runSync[0], runEnable};

        // Receive shift on rising clock
        if ((r.st == ASCP_D_ADDR || r.st == ASCP_D_REG || r.st == ASCP_D_DATA)
            && sclRise && r.bitCnt < `ASCP_BYTE_BITS) begin
            n.shift  = {r.shift[6:0], sdaH};
            n.bitCnt = r.bitCnt + 4'h1;
        end

        case (r.st)
            ASCP_D_IDLE: begin
                n.sdaOe = 1'b0;
            end
            ASCP_D_ADDR: begin
                if (sclFall && r.bitCnt == `ASCP_BYTE_BITS) begin
                    n.bitCnt = 4'h0;
                    if (r.shift[7:1] == `ASCP_DEV_ADDR) begin
                        n.sdaOe   = 1'b1;
                        n.rw      = r.shift[0];
                        n.ackKind = 2'h0;
                        n.st      = ASCP_D_ACK;
                    end else begin
                        n.st = ASCP_D_IDLE;
                    end
                end
            end
            ASCP_D_REG: begin
                if (sclFall && r.bitCnt == `ASCP_BYTE_BITS) begin
                    n.bitCnt  = 4'h0;
                    n.regAddr = r.shift;
                    n.sdaOe   = 1'b1;
                    n.ackKind = 2'h1;
                    n.st      = ASCP_D_ACK;
                end
            end
            ASCP_D_DATA: begin
                if (sclFall && r.bitCnt == `ASCP_BYTE_BITS) begin
                    n.bitCnt  = 4'h0;
                    n.sdaOe   = 1'b1;
                    n.ackKind = 2'h2;
                    n.st      = ASCP_D_ACK;
                    case (r.regAddr)
                        `ASCP_REG_PWR:  n.pwr  = r.shift & `ASCP_PWR_MASK;
                        `ASCP_REG_LIM:  n.lim  = r.shift & `ASCP_LIM_MASK;
                        `ASCP_REG_GAIN: n.gain = r.shift & `ASCP_GAIN_MASK;
                        default:        n.pwr  = r.pwr;
                    endcase
                end
            end
            ASCP_D_ACK: begin
                if (sclFall) begin
                    n.sdaOe = 1'b0;
                    case (r.ackKind)
                        2'h0:    n.st = ASCP_D_REG;
                        2'h1: begin
                            if (r.rw) begin
                                n.st     = ASCP_D_TX;
                                n.bitCnt = 4'h0;
                                n.sdaOe  = !rdData[7];
                                n.shift  = {rdData[6:0], 1'b0};
                            end else begin
                                n.st = ASCP_D_DATA;
                            end
                        end
                        default: n.st = ASCP_D_IDLE;
                    endcase
                end
            end
            ASCP_D_TX: begin
                if (sclRise) begin
                    n.bitCnt = r.bitCnt + 4'h1;
                end
                if (sclFall) begin
                    if (r.bitCnt == `ASCP_BYTE_BITS) begin
                        n.sdaOe = 1'b0;
                        n.st    = ASCP_D_MACK;
                    end else begin
                        n.sdaOe = !r.shift[7];
                        n.shift = {r.shift[6:0], 1'b0};
                    end
                end
            end
            ASCP_D_MACK: begin
                if (sclFall) begin
                    n.st = ASCP_D_IDLE;
                end
            end
            default: begin
                n.st    = ASCP_D_IDLE;
                n.sdaOe = 1'b0;
            end
        endcase

        // Bus conditions override the byte engine
        if (stopC) begin
            n.st    = ASCP_D_IDLE;
            n.sdaOe = 1'b0;
        end
        if (startC) begin
            n.st     = ASCP_D_ADDR;
            n.bitCnt = 4'h0;
            n.sdaOe  = 1'b0;
        end
        if (!swMode) begin
            n.st    = ASCP_D_IDLE;
            n.sdaOe = 1'b0;
        end

        // Amplifier settings from registers or pins
        if (swMode) begin
            n.ampOn        = r.pwr[`ASCP_PWR_RUN] && runPin;
            n.boostOn      = r.pwr[`ASCP_PWR_BOOST] && runPin;
            n.secondInput  = r.pwr[`ASCP_PWR_INSEL];
            n.fastWake     = r.pwr[`ASCP_PWR_FAST];
            n.levelCode    = r.gain[1:0];
            n.limiterOn    = runPin && r.pwr[`ASCP_PWR_RUN] && r.pwr[`ASCP_PWR_BOOST]
                             && cap != `ASCP_CAP_OFF_LO && cap != `ASCP_CAP_OFF_HI;
            n.onsetCode    = r.lim[`ASCP_LIM_ONS_LSB +: 2];
            n.recoveryCode = r.lim[`ASCP_LIM_REC_LSB +: 2];
            n.capCode      = cap;
        end else begin
            n.ampOn        = runPin;
            n.boostOn      = runPin && sdaH;
            n.secondInput  = sdaH;
            n.fastWake     = 1'b0;
            n.levelCode    = sdaH ? {sclH, 1'b1} : {1'b0, sclH};
            n.limiterOn    = 1'b0;
            n.onsetCode    = 2'h0;
            n.recoveryCode = 2'h0;
            n.capCode      = 3'h0;
        end
    end

    // State register, clear at reset except clock and data synchronisers and previous values held high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r         <= '0;
            r.sclSync <= 2'h3;
            r.sclPrev <= 1'b1;
            r.sdaSync <= 2'h3;
            r.sdaPrev <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Open-drain data line; clock line is input only
    assign bus.sdaDevOut = 1'b0;
    assign bus.sdaDevOe  = r.sdaOe;
    assign ampOn         = r.ampOn;
    assign boostOn       = r.boostOn;
    assign secondInput   = r.secondInput;
    assign fastWake      = r.fastWake;
    assign levelCode     = r.levelCode;
    assign limiterOn     = r.limiterOn;
    assign onsetCode     = r.onsetCode;
    assign recoveryCode  = r.recoveryCode;
    assign capCode       = r.capCode;
endmodule : ascp_device
`default_nettype wire

// ### common/ascp_consts.svh
// Constants for the amplifier serial control port
`ifndef ASCP_CONSTS_SVH
`define ASCP_CONSTS_SVH
// Bus identity and framing
`define ASCP_DEV_ADDR     7'h6F
`define ASCP_BYTE_BITS    4'h8
// Register offsets
`define ASCP_REG_PWR      8'h00
`define ASCP_REG_LIM      8'h01
`define ASCP_REG_GAIN     8'h02
`define ASCP_REG_TEST     8'h03
// Reset value and writable masks
`define ASCP_REG_RST      8'h00
`define ASCP_PWR_MASK     8'h0F
`define ASCP_LIM_MASK     8'h7F
`define ASCP_GAIN_MASK    8'h03
// Field positions
`define ASCP_PWR_RUN      0
`define ASCP_PWR_BOOST    1
`define ASCP_PWR_INSEL    2
`define ASCP_PWR_FAST     3
`define ASCP_LIM_CAP_LSB  0
`define ASCP_LIM_ONS_LSB  3
`define ASCP_LIM_REC_LSB  5
// Limit codes that switch the limiter off
`define ASCP_CAP_OFF_LO   3'h0
`define ASCP_CAP_OFF_HI   3'h7
// Wake-up times, analogue, for reference
`define ASCP_WAKE_NORM_MS 15
`define ASCP_WAKE_FAST_MS 5
// Timing
`define ASCP_CLK_KHZ      20000
`define ASCP_SCL_KHZ      400
`define ASCP_QUARTER_CYC  ((`ASCP_CLK_KHZ + 4 * `ASCP_SCL_KHZ - 1) / (4 * `ASCP_SCL_KHZ))
// Host frame: three 9-bit bytes as 27 bit slots, last slot index
`define ASCP_LAST_SLOT    5'd26
// Host APB map
`define ASCP_APB_CMD      8'h00
`define ASCP_APB_STAT     8'h04
`define ASCP_CMD_READ     16
`endif

// ### common/ascp_pkg.sv
// Types for the amplifier serial control port
package ascp_pkg;
    typedef enum logic [2:0] {
        ASCP_D_IDLE = 3'h0,
        ASCP_D_ADDR = 3'h1,
        ASCP_D_ACK  = 3'h3,
        ASCP_D_REG  = 3'h2,
        ASCP_D_DATA = 3'h6,
        ASCP_D_TX   = 3'h7,
        ASCP_D_MACK = 3'h5
    } ascp_dev_st_t;

    typedef enum logic [1:0] {
        ASCP_H_IDLE  = 2'h0,
        ASCP_H_START = 2'h1,
        ASCP_H_BITS  = 2'h3,
        ASCP_H_STOP  = 2'h2
    } ascp_host_st_t;

    typedef struct packed {
        logic [1:0]   sclSync;
        logic         sclPrev;
        logic [1:0]   sdaSync;
        logic         sdaPrev;
        logic [1:0]   modeSync;
        logic [1:0]   runSync;
        ascp_dev_st_t st;
        logic [1:0]   ackKind;
        logic [3:0]   bitCnt;
        logic [7:0]   shift;
        logic         rw;
        logic [7:0]   regAddr;
        logic [7:0]   pwr;
        logic [7:0]   lim;
        logic [7:0]   gain;
        logic         sdaOe;
        logic         ampOn;
        logic         boostOn;
        logic         secondInput;
        logic         fastWake;
        logic [1:0]   levelCode;
        logic         limiterOn;
        logic [1:0]   onsetCode;
        logic [1:0]   recoveryCode;
        logic [2:0]   capCode;
    } ascp_dev_t;

    typedef struct packed {
        logic          pready;
        logic [31:0]   prdata;
        logic [1:0]    sdaSync;
        ascp_host_st_t st;
        logic [1:0]    q;
        logic [4:0]    cnt;
        logic [4:0]    slot;
        logic [26:0]   txFrame;
        logic [26:0]   rxFrame;
        logic          rdFlag;
        logic          busy;
        logic          nack;
        logic [7:0]    rdData;
        logic          scl;
        logic          sdaOe;
    } ascp_host_t;
endpackage : ascp_pkg

// ### common/ascp_if.sv
// Two-wire link between host and amplifier control port
`timescale 1ns/10ps
`default_nettype none
interface ascp_if;
    logic scl;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic sda;

    // Open-drain wire with pull-up
    assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

    modport host (output scl, output sdaHostOut, output sdaHostOe, input sda);
    modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
endinterface : ascp_if
`default_nettype wire

// ### design/ascp_host.sv
// Two-wire bus master with APB command and status registers
`timescale 1ns/10ps
`default_nettype none
`include "ascp_consts.svh"

module ascp_host #(
    parameter int QUARTER = `ASCP_QUARTER_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    ascp_if.host             bus,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import ascp_pkg::*;

    ascp_host_t r;
    ascp_host_t n;
    logic       tick;
    logic       access;
    logic       rd;

    assign access = psel && penable;
    assign rd     = pwdata[`ASCP_CMD_READ];
    assign tick   = r.busy && r.cnt == 5'(QUARTER - 1);

    // Next state
    always_comb begin
        n = r;
        n.sdaSync = {r.sdaSync[0], bus.sda};

        // APB slave: one wait state, answer registered
        n.pready = access && !r.pready;
        if (access && !r.pready) begin
            if (paddr == `ASCP_APB_STAT) begin
                n.prdata = {16'h0000, r.rdData, 6'h00, r.nack, r.busy};
            end else begin
                n.prdata = 32'h0000_0000;
            end
        end
        if (access && r.pready && pwrite && paddr == `ASCP_APB_CMD && !r.busy) begin
            n.txFrame = {`ASCP_DEV_ADDR, rd, 1'b1, pwdata[7:0], 1'b1,
                         rd ? 8'hFF : pwdata[15:8], 1'b1};
            n.rdFlag  = rd;
            n.busy    = 1'b1;
            n.st      = ASCP_H_START;
            n.q       = 2'h0;
            n.cnt     = 5'h00;
            n.slot    = 5'h00;
        end

        // Quarter-period divider
        if (r.busy) begin
            n.cnt = tick ? 5'h00 : r.cnt + 5'h01;
        end

        if (tick) begin
            n.q = r.q + 2'h1;
            case (r.st)
                ASCP_H_START: begin
                    case (r.q)
                        2'h0:    n.sdaOe = 1'b0;
                        2'h1:    n.sdaOe = 1'b1;
                        2'h3: begin
                            n.scl  = 1'b0;
                            n.st   = ASCP_H_BITS;
                            n.slot = 5'h00;
                        end
                        default: n.scl = 1'b1;
                    endcase
                end
                ASCP_H_BITS: begin
                    case (r.q)
                        2'h0:    n.sdaOe = !r.txFrame[26];
                        2'h1:    n.scl = 1'b1;
                        2'h2:    n.rxFrame = {r.rxFrame[25:0], r.sdaSync[1]};
                        default: begin
                            n.scl     = 1'b0;
                            n.txFrame = {r.txFrame[25:0], 1'b1};
                            if (r.slot == `ASCP_LAST_SLOT) begin
                                n.st = ASCP_H_STOP;
                            end else begin
                                n.slot = r.slot + 5'h01;
                            end
                        end
                    endcase
                end
                ASCP_H_STOP: begin
                    case (r.q)
                        2'h0:    n.sdaOe = 1'b1;
                        2'h1:    n.scl = 1'b1;
                        2'h2:    n.sdaOe = 1'b0;
                        default: begin
                            n.st     = ASCP_H_IDLE;
                            n.busy   = 1'b0;
                            n.nack   = r.rxFrame[18] || r.rxFrame[9]
                                       || (!r.rdFlag && r.rxFrame[0]);
                            n.rdData = r.rdFlag ? r.rxFrame[8:1] : r.rdData;
                        end
                    endcase
                end
                default: begin
                    n.st   = ASCP_H_IDLE;
                    n.busy = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r         <= '0;
            r.sdaSync <= 2'h3;
            r.scl     <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign bus.scl        = r.scl;
    assign bus.sdaHostOut = 1'b0;
    assign bus.sdaHostOe  = r.sdaOe;
    assign prdata         = r.prdata;
    assign pready         = r.pready;
    assign pslverr        = 1'b0;
endmodule : ascp_host
`default_nettype wire

// ### verif/ascp_monitor.sv
// Link checker for the amplifier serial control port
`timescale 1ns/10ps
`default_nettype none
module ascp_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sdaHostOut,
    input wire logic sdaHostOe,
    input wire logic sdaDevOut,
    input wire logic sdaDevOe,
    input wire logic sda
);
    logic [9:0] oeRun;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Length of one unbroken device drive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oeRun <= 10'h000;
        end else begin
            oeRun <= sdaDevOe ? oeRun + 10'h001 : 10'h000;
        end
    end

    // Bus events made by the master
    sequence hostStart;
        $fell(sda) && scl;
    endsequence
    sequence hostStop;
        $rose(sda) && scl;
    endsequence
    sequence lowThenHigh;
        !scl[*8] ##[10:30] scl;
    endsequence

    dev_open_drain_a: assert property (sdaDevOut == 1'b0 && sdaHostOut == 1'b0)
        else $error("an end drives the data line high");
    dev_steady_high_a: assert property (scl && $past(scl) |-> $stable(sdaDevOe))
        else $error("device changed the data line while the clock was high");
    ack_when_low_a: assert property ($rose(sdaDevOe) |-> !scl)
        else $error("device started driving while the clock was high");
    ack_holds_a: assert property ($rose(sdaDevOe) |-> sdaDevOe[*8])
        else $error("device drive shorter than a clock low phase");
    no_contention_a: assert property ($rose(scl) && sdaDevOe |-> !sdaHostOe)
        else $error("both ends drive the data line at a sampling edge");
    start_by_host_a: assert property (hostStart |-> sdaHostOe && !sdaDevOe)
        else $error("start condition not made by the master alone");
    stop_by_host_a: assert property (hostStop |-> !sdaDevOe)
        else $error("device held the data line through a stop");
    clock_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
    clock_low_a: assert property ($fell(scl) |-> lowThenHigh)
        else $error("clock low phase out of range");
    drive_bound_a: assert property (oeRun < 10'd500)
        else $error("device held the data line longer than one byte");
endmodule : ascp_monitor
`default_nettype wire

// ### verif/test_amp_serial_control_port.sv
// Bench: host and control port joined on one link
`timescale 1ns/10ps
`default_nettype none
`include "ascp_consts.svh"
module test_amp_serial_control_port;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, st;
    logic        modePin = 1'b1, runPin = 1'b1, sclB = 1'b1, selB = 1'b1;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [13:0] outs, outsB;
    logic [7:0]  shadow [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  masks [3] = '{`ASCP_PWR_MASK, `ASCP_LIM_MASK, `ASCP_GAIN_MASK};
    logic [15:0] rows [12] = '{16'h00FF, 16'h01FF, 16'h012A, 16'h0148, 16'h017E, 16'h02FF,
                               16'h0201, 16'h03A5, 16'h075A, 16'h0005, 16'h000A, 16'h0003};
    int          nFail = 0, nTests = 0;

    ascp_if bus ();
    ascp_if busB ();
    // Second link: bench holds the shared pins as static selects
    assign busB.scl = sclB;
    assign busB.sdaHostOut = 1'b0;
    assign busB.sdaHostOe = !selB;

    ascp_host i_ascp_host (.clk(clk), .rstn(rstn), .bus(bus.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ascp_device i_ascp_device (.clk(clk), .rstn(rstn), .bus(bus.device),
        .controlSourcePin(modePin), .runEnable(runPin), .ampOn(outs[13]),
        .boostOn(outs[12]), .secondInput(outs[11]), .fastWake(outs[10]),
        .levelCode(outs[9:8]), .limiterOn(outs[7]), .onsetCode(outs[6:5]),
        .recoveryCode(outs[4:3]), .capCode(outs[2:0]));
    ascp_device i_ascp_device_b (.clk(clk), .rstn(rstn), .bus(busB.device),
        .controlSourcePin(1'b0), .runEnable(runPin), .ampOn(outsB[13]),
        .boostOn(outsB[12]), .secondInput(outsB[11]), .fastWake(outsB[10]),
        .levelCode(outsB[9:8]), .limiterOn(outsB[7]), .onsetCode(outsB[6:5]),
        .recoveryCode(outsB[4:3]), .capCode(outsB[2:0]));
    ascp_monitor i_ascp_monitor (.clk(clk), .rstn(rstn), .scl(bus.scl),
        .sdaHostOut(bus.sdaHostOut), .sdaHostOe(bus.sdaHostOe), .sdaDevOut(bus.sdaDevOut),
        .sdaDevOe(bus.sdaDevOe), .sda(bus.sda));

    // 20 MHz clock
    always #25 clk = ~clk;

    // Expected register-mode outputs
    function automatic logic [13:0] expOuts(input logic [7:0] p, l, g, input logic run);
        logic capOn;
        capOn = l[2:0] != `ASCP_CAP_OFF_LO && l[2:0] != `ASCP_CAP_OFF_HI;
        expOuts = {p[0] & run, p[1] & run, p[2], p[3], g[1:0], run & p[0] & p[1] & capOn,
                   l[4:3], l[6:5], l[2:0]};
    endfunction : expOuts

    task automatic checkByte(input string what, input logic [7:0] e, input logic [7:0] g);
        nTests++;
        if (g !== e) begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : checkByte

    task automatic checkOuts(input string what, input logic [13:0] e, input logic [13:0] g);
        nTests++;
        if (g !== e) begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : checkOuts

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        st = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic waitIdle;
        do begin
            apb(1'b0, `ASCP_APB_STAT, 32'h0);
        end while (st[0] !== 1'b0);
    endtask : waitIdle

    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
        apb(1'b1, `ASCP_APB_CMD, {15'h0, rd, d, a});
        waitIdle();
    endtask : xfer

    task automatic checkCleared;
        for (int a = 0; a < 4; a++) begin
            xfer(a[7:0], 8'h00, 1'b1);
            checkByte("cleared register", 8'h00, st[15:8]);
        end
        checkOuts("outputs after reset", 14'h0000, outs);
        $display("test reset values done");
    endtask : checkCleared

    task automatic summarize;
        $display("checks %0d, mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        checkCleared();
        foreach (rows[i]) begin
            xfer(rows[i][15:8], rows[i][7:0], 1'b0);
            checkByte("nack flag", 8'h00, {7'h0, st[1]});
            if (rows[i][15:8] < 8'h03) begin
                shadow[rows[i][9:8]] = rows[i][7:0] & masks[rows[i][9:8]];
            end
            xfer(rows[i][15:8], 8'h00, 1'b1);
            checkByte("readback", (rows[i][15:8] < 8'h03) ? shadow[rows[i][9:8]] : 8'h00,
                st[15:8]);
            checkOuts("settings", expOuts(shadow[0], shadow[1], shadow[2], 1'b1), outs);
        end
        $display("test register table done");
        // Second command while busy is dropped
        apb(1'b1, `ASCP_APB_CMD, 32'h0000_0202);
        apb(1'b1, `ASCP_APB_CMD, 32'h0000_0102);
        waitIdle();
        shadow[2] = 8'h02;
        xfer(8'h02, 8'h00, 1'b1);
        checkByte("busy refusal", 8'h02, st[15:8]);
        apb(1'b0, 8'h08, 32'h0);
        checkByte("unmapped apb", 8'h00, st[7:0] | st[15:8] | st[23:16] | st[31:24]);
        checkByte("slave error", 8'h00, {7'h0, pslverr});
        $display("test busy and unmapped done");
        // Hardware mode: bus ignored, idle pins act as selects
        modePin <= 1'b0;
        repeat (8) @(posedge clk);
        checkOuts("hardware idle", {4'hE, 2'h3, 8'h00}, outs);
        xfer(8'h00, 8'h0F, 1'b0);
        checkByte("hardware nack", 8'h01, {7'h0, st[1]});
        modePin <= 1'b1;
        repeat (8) @(posedge clk);
        xfer(8'h00, 8'h00, 1'b1);
        checkByte("kept register", shadow[0], st[15:8]);
        for (int k = 0; k < 4; k++) begin
            selB <= k[1];
            sclB <= k[0];
            repeat (8) @(posedge clk);
            checkOuts("pin select", {1'b1, k[1], k[1], 1'b0, k[1] ? {k[0], 1'b1} : {1'b0, k[0]},
                8'h00}, outsB);
        end
        $display("test hardware mode done");
        // Shutdown pin overrides registers
        runPin <= 1'b0;
        repeat (8) @(posedge clk);
        checkOuts("shutdown", expOuts(shadow[0], shadow[1], shadow[2], 1'b0), outs);
        checkOuts("pin shutdown", {3'h0, 3'h0, 8'h00}, outsB & 14'h3000);
        runPin <= 1'b1;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        checkCleared();
        summarize();
    end

    // Watchdog
    initial begin
        #4000000;
        nFail++;
        $display("unexpected run time: expected finish, seen hang");
        summarize();
    end
endmodule : test_amp_serial_control_port
`default_nettype wire
